// ---- hdl/asbp_host.sv ----
// Host-side controller that drives an asynchronous byte-wide SRAM port.
// Assumes the SRAM pins are sampled/driven on clk; the bench resolves the bus.
`timescale 1ns/1ps
`default_nettype none
module asbp_host #(
    parameter int ADDR_W = asbp_pkg::ADDR_W,
    parameter int DATA_W = asbp_pkg::DATA_W
) (
    input  wire logic              clk,
    input  wire logic              srst,
    // User request side
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic              power_ok,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   req_error,
    // SRAM pins
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_select_n,
    output logic                   mem_oe_n,
    output logic                   mem_we_n,
    output logic [DATA_W-1:0]      data_bus_o,
    output logic                   data_bus_oe,
    input  wire logic [DATA_W-1:0] data_bus_i
);
    ////////////////////////////////////////////////////////////////////
    // Timer link
    asbp_timer_if tif ();
    asbp_timer u_timer (
        .clk  (clk),
        .srst (srst),
        .t    (tif.tmr)
    );

    asbp_pkg::asbp_state_t state_q;    // Sequencer state
    logic [ADDR_W-1:0]     addr_q;     // Latched address
    logic [DATA_W-1:0]     wdata_q;    // Latched write data
    logic                  sel_n_q;    // Chip select pin
    logic                  oe_n_q;     // Output enable pin
    logic                  we_n_q;     // Write enable pin
    logic                  drv_q;      // Host drives data bus
    logic                  ready_q;    // Ready for a request
    logic                  rsp_q;      // Read answer pulse
    logic [DATA_W-1:0]     rdata_q;    // Captured read byte
    logic                  err_q;      // Refused request pulse
    logic                  load_q;     // Timer load pulse
    logic [7:0]            cnt_q;      // Timer count

    // Address range check, used for refusal
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return a <= asbp_pkg::LAST_ADDR;
    endfunction

    // Request decode as named wires
    wire take    = ready_q && req_valid;
    wire take_ok = take && power_ok && addr_ok(req_addr);
    wire take_bad = take && !take_ok;

    assign tif.load  = load_q;
    assign tif.count = cnt_q;

    ////////////////////////////////////////////////////////////////////
    // Sequencer: one access at a time, timed by the shared counter
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= asbp_pkg::ASBP_IDLE;
            addr_q  <= '0;
            wdata_q <= '0;
            sel_n_q <= 1'b1;
            oe_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            drv_q   <= 1'b0;
            ready_q <= 1'b1;
            rsp_q   <= 1'b0;
            rdata_q <= '0;
            err_q   <= 1'b0;
            load_q  <= 1'b0;
            cnt_q   <= 8'h00;
        end else begin
            rsp_q  <= 1'b0;
            err_q  <= take_bad;
            load_q <= 1'b0;
            unique case (state_q)
                asbp_pkg::ASBP_IDLE: begin
                    // Accept only while device is powered and out of recovery
                    if (take_ok) begin
                        ready_q <= 1'b0;
                        addr_q  <= req_addr;
                        wdata_q <= req_wdata;
                        load_q  <= 1'b1;
                        if (req_write) begin
                            // Enable stays high so the device never drives
                            oe_n_q  <= 1'b1;
                            // Select and write fall together; the host drives the bus from the same edge
                            sel_n_q <= 1'b0;
                            we_n_q  <= 1'b0;
                            drv_q   <= 1'b1;
                            cnt_q   <= 8'(asbp_pkg::WR_PULSE_CYC > asbp_pkg::ADDR_END_CYC
                                ? asbp_pkg::WR_PULSE_CYC : asbp_pkg::ADDR_END_CYC);
                            state_q <= asbp_pkg::ASBP_WR_PULSE;
                        end else begin
                            sel_n_q <= 1'b0;
                            oe_n_q  <= 1'b0;
                            we_n_q  <= 1'b1;
                            // Worst of address, select and enable paths
                            cnt_q   <= 8'(asbp_pkg::RD_ACCESS_CYC + 1);
                            state_q <= asbp_pkg::ASBP_RD_ACC;
                        end
                    end
                end
                asbp_pkg::ASBP_RD_ACC: begin
                    // Address held fixed so no hold-time window applies
                    if (tif.done) begin
                        rdata_q <= data_bus_i;
                        rsp_q   <= 1'b1;
                        sel_n_q <= 1'b1;
                        oe_n_q  <= 1'b1;
                        load_q  <= 1'b1;
                        cnt_q   <= 8'(asbp_pkg::RELEASE_CYC);
                        state_q <= asbp_pkg::ASBP_RD_DONE;
                    end
                end
                asbp_pkg::ASBP_RD_DONE: begin
                    // Wait for the device to float the bus
                    if (tif.done) begin
                        load_q  <= 1'b1;
                        cnt_q   <= 8'(asbp_pkg::CYCLE_CYC);
                        state_q <= asbp_pkg::ASBP_RECOVER;
                    end
                end
                asbp_pkg::ASBP_WR_PULSE: begin
                    // Both edges rise together; this edge commits the byte
                    if (tif.done) begin
                        sel_n_q <= 1'b1;
                        we_n_q  <= 1'b1;
                        load_q  <= 1'b1;
                        cnt_q   <= 8'(asbp_pkg::WR_HOLD_CYC);
                        state_q <= asbp_pkg::ASBP_WR_HOLD;
                    end
                end
                asbp_pkg::ASBP_WR_HOLD: begin
                    // Data and address stay after the terminating edge
                    if (tif.done) begin
                        drv_q   <= 1'b0;
                        load_q  <= 1'b1;
                        cnt_q   <= 8'(asbp_pkg::CYCLE_CYC);
                        state_q <= asbp_pkg::ASBP_RECOVER;
                    end
                end
                asbp_pkg::ASBP_RECOVER: begin
                    // Strobes high before the next access
                    if (tif.done) begin
                        ready_q <= 1'b1;
                        state_q <= asbp_pkg::ASBP_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign req_ready    = ready_q;
    assign rsp_valid    = rsp_q;
    assign rsp_rdata    = rdata_q;
    assign req_error    = err_q;
    assign mem_addr     = addr_q;
    assign mem_select_n = sel_n_q;
    assign mem_oe_n     = oe_n_q;
    assign mem_we_n     = we_n_q;
    assign data_bus_o   = wdata_q;
    assign data_bus_oe  = drv_q;
endmodule
`default_nettype wire

// ---- hdl/asbp_pkg.sv ----
// Shared constants and types for the asynchronous SRAM host port.
// Assumes a single 50 MHz clock; all pin timing is derived from it.
package asbp_pkg;
    // Clock period in picoseconds
    localparam int CLK_PS            = 20000;
    // Memory geometry
    localparam int ADDR_W            = 13;
    localparam int DATA_W            = 8;
    localparam logic [12:0] LAST_ADDR = 13'h1FEF;   // 8,176 bytes
    // Device timing figures in ns
    localparam int ADDRESS_ACCESS_TIME_NS       = 70;
    localparam int SELECT_ACCESS_TIME_NS        = 70;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 35;
    localparam int OUTPUT_HOLD_TIME_NS          = 10;
    localparam int RELEASE_TIME_NS              = 25;
    localparam int DATA_SETUP_NS                = 30;
    localparam int DATA_HOLD_NS                 = 5;
    localparam int WRITE_PULSE_NS               = 50;
    localparam int SELECT_PULSE_NS              = 55;
    localparam int ADDR_TO_END_NS               = 60;
    localparam int CYCLE_TIME_NS                = 70;
    // Least times round up, at least one cycle
    function automatic int ns_up(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RD_ACCESS_CYC = ns_up(ADDRESS_ACCESS_TIME_NS);
    localparam int OE_ACCESS_CYC = ns_up(OUTPUT_ENABLE_ACCESS_TIME_NS);
    localparam int RELEASE_CYC   = ns_up(RELEASE_TIME_NS);
    localparam int WR_PULSE_CYC  = ns_up(SELECT_PULSE_NS);
    localparam int WR_SETUP_CYC  = ns_up(DATA_SETUP_NS);
    localparam int WR_HOLD_CYC   = ns_up(DATA_HOLD_NS);
    localparam int ADDR_END_CYC  = ns_up(ADDR_TO_END_NS);
    localparam int CYCLE_CYC     = ns_up(CYCLE_TIME_NS);
    // Host sequencer states
    typedef enum logic [2:0] {
        ASBP_IDLE, ASBP_RD_ACC, ASBP_RD_DONE, ASBP_WR_PULSE, ASBP_WR_HOLD, ASBP_RECOVER
    } asbp_state_t;
endpackage

// ---- hdl/asbp_timer.sv ----
// Down counter that times pin phases for the SRAM host port.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module asbp_timer (
    input  wire logic   clk,
    input  wire logic   srst,
    asbp_timer_if.tmr   t
);
    logic [7:0] cnt_q;   // Remaining cycles

    // Reload on request, else count to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= 8'h00;
        end else if (t.load) begin
            cnt_q <= t.count;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign t.done = (cnt_q == 8'h00) && !t.load;
endmodule
`default_nettype wire

// ---- hdl/asbp_timer_if.sv ----
// Interface between the host sequencer and its cycle timer.
// Assumes both ends share the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface asbp_timer_if;
    logic       load;    // Start a count
    logic [7:0] count;   // Cycles to count
    logic       done;    // Count has elapsed (level)
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// ---- sim/asbp_host_properties.sv ----
// Pin-timing checker for the SRAM host port, bound to asbp_host.
// Assumes one clock domain with srst as its synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module asbp_host_properties (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        power_ok,
    input wire logic        req_error,
    input wire logic        rsp_valid,
    input wire logic        mem_select_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic [12:0] mem_addr,
    input wire logic [7:0]  data_bus_o,
    input wire logic        data_bus_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    a_oe_high_wr:    assert property (!mem_we_n |-> mem_oe_n) else $error("oe low in write");
    a_addr_stable:   assert property (!mem_we_n && !$past(mem_we_n)
        |-> $stable(mem_addr)) else $error("address moved in write");
    a_data_setup:    assert property (!mem_we_n && !$past(mem_we_n)
        |-> $stable(data_bus_o)) else $error("write data moved");
    a_data_hold:     assert property ($rose(mem_we_n)
        |-> data_bus_oe && $stable(data_bus_o)) else $error("write data not held");
    a_we_pulse:      assert property ($fell(mem_we_n) |-> !mem_we_n [*3])
        else $error("write pulse short");
    // Strobes fall on the take edge, the byte is sampled seven edges later
    a_read_answer:   assert property ($fell(mem_oe_n) |-> ##7 rsp_valid)
        else $error("read answer late");
    a_refuse_power:  assert property (req_valid && req_ready && !power_ok
        |=> req_error && mem_select_n) else $error("request not refused");
    a_strobes_pair:  assert property ($fell(mem_we_n) |-> $fell(mem_select_n))
        else $error("select and write apart");
    a_no_contend:    assert property (!mem_oe_n |-> !data_bus_oe) else $error("bus contention");
endmodule
bind asbp_host asbp_host_properties u_props (.clk(clk), .srst(srst), .req_valid(req_valid),
    .req_ready(req_ready), .power_ok(power_ok), .req_error(req_error), .rsp_valid(rsp_valid),
    .mem_select_n(mem_select_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .mem_addr(mem_addr), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe));
`default_nettype wire

// ---- sim/asbp_sram_model.sv ----
// Behavioural byte-wide SRAM answering the host port, timed in ns.
// Assumes the bench resolves the shared data bus and feeds it back as din.
`timescale 1ns/1ps
`default_nettype none
module asbp_sram_model (
    input  wire logic [12:0] addr,
    input  wire logic        select_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  din,
    input  wire logic        power_ok,
    output logic [7:0]       dout,
    output logic             dout_en
);
    logic [7:0] mem [0:8175];
    logic       in_wr = 1'b0;
    logic       valid = 1'b0;
    realtime    t_a = 0.0;
    realtime    t_g = 0.0;
    // Address clock restarts on address or select, enable clock on enable fall; data goes bad within one step
    always @(addr or negedge select_n) begin
        t_a = $realtime;
    end
    always @(negedge oe_n) t_g = $realtime;
    always #1 valid = ($realtime - t_a >= 70.0) && ($realtime - t_g >= 35.0);
    assign dout_en = power_ok && !select_n && !oe_n && we_n;
    assign dout = valid ? mem[addr] : ~mem[addr];
    always @(negedge we_n or negedge select_n) in_wr = power_ok && !we_n && !select_n;
    // Commit on the first rising strobe only
    always @(posedge we_n or posedge select_n) begin
        if (in_wr && power_ok) mem[addr] = din;
        in_wr = 1'b0;
    end
    // Contents kept while power is low: the cell array stays on battery
    always @(negedge power_ok) in_wr = 1'b0;
endmodule
`default_nettype wire

// ---- sim/tb_async_sram_bus_port.sv ----
// Self-checking bench: host port against a behavioural SRAM.
// Assumes a 50 MHz clock and the request handshake of the host port.
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_bus_port;
    logic        clk, srst, req_valid, req_write, power_ok, req_ready, rsp_valid, req_error;
    logic        sel_n, oe_n, we_n, host_oe, dev_oe;
    logic [12:0] req_addr, mem_addr;
    logic [7:0]  req_wdata, rsp_rdata, host_o, dev_o, bus;
    logic [7:0]  last_q = 8'h00;   // Last driven bus value
    logic [12:0] tab [4] = '{13'h0000, 13'h0001, 13'h0155, 13'h1FEF};
    int          n_fail = 0;
    int          n_compared = 0;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Undriven bus shows the inverse of its last value
    assign bus = host_oe ? host_o : (dev_oe ? dev_o : ~last_q);
    always @(posedge clk) if (host_oe || dev_oe) last_q <= bus;
    asbp_host uut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .power_ok(power_ok), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .req_error(req_error),
        .mem_addr(mem_addr), .mem_select_n(sel_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
        .data_bus_o(host_o), .data_bus_oe(host_oe), .data_bus_i(bus));
    asbp_sram_model dev (.addr(mem_addr), .select_n(sel_n), .oe_n(oe_n), .we_n(we_n),
        .din(bus), .power_ok(power_ok), .dout(dev_o), .dout_en(dev_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One request; waits are bounded, a timeout ends the run
    task automatic xfer(input logic wr, input logic [12:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic err);
        int i;
        logic busy, fin;
        q = 8'h00;
        err = 1'b0;
        busy = 1'b0;
        fin = 1'b0;
        for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge clk);
        // Ready never came back: count it and stop
        if (req_ready !== 1'b1) begin
            n_fail++;
            close_out();
        end
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        for (i = 0; i < 40 && !fin; i++) begin
            @(negedge clk);
            if (req_error === 1'b1) err = 1'b1;
            if (rsp_valid === 1'b1) q = rsp_rdata;
            if (req_ready === 1'b0) busy = 1'b1;
            fin = err || rsp_valid === 1'b1 || (wr && busy && req_ready === 1'b1);
        end
        if (!fin) begin
            n_fail++;
            close_out();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_write_read;
        logic [7:0] q;
        logic e;
        for (int i = 0; i < 4; i++) xfer(1'b1, tab[i], tab[i][7:0] ^ 8'h5A, q, e);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, tab[i], 8'h00, q, e);
            check(q, tab[i][7:0] ^ 8'h5A);
        end
        $display("test write_read done");
    endtask
    task automatic t_refuse;
        logic [7:0] q;
        logic e;
        xfer(1'b0, 13'h1FF0, 8'h00, q, e);
        check({7'h00, e}, 8'h01);
        xfer(1'b1, 13'h1FF0, 8'hC3, q, e);
        check({7'h00, e}, 8'h01);
        @(posedge clk) power_ok <= 1'b0;
        xfer(1'b1, 13'h0001, 8'hFF, q, e);
        check({7'h00, e}, 8'h01);
        @(posedge clk) power_ok <= 1'b1;
        xfer(1'b0, 13'h0001, 8'h00, q, e);
        check(q, 8'h5B);
        $display("test refuse done");
    endtask
    task automatic t_overwrite;
        logic [7:0] q;
        logic e;
        xfer(1'b1, 13'h0155, 8'h00, q, e);
        xfer(1'b1, 13'h0155, 8'h3C, q, e);
        xfer(1'b0, 13'h0155, 8'h00, q, e);
        check(q, 8'h3C);
        xfer(1'b0, 13'h1FEF, 8'h00, q, e);
        check(q, 8'hB5);
        $display("test overwrite done");
    endtask
    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 13'h0000;
        req_wdata = 8'h00;
        power_ok = 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_write_read();
        t_refuse();
        t_overwrite();
        close_out();
    end
endmodule
`default_nettype wire
